/* inc/rtc_pkg.sv */
// constants shared by the timer/alarm block and its helpers
package rtc_pkg;

  // register byte offsets on the apb port
  localparam logic [7:0] OFF_CONTROL = 8'h04;
  localparam logic [7:0] OFF_CAPTURE = 8'h08;
  localparam logic [7:0] OFF_MATCH = 8'h0c;
  localparam logic [7:0] OFF_ALARM_CFG = 8'h10;

  // control register field positions
  localparam int BIT_OSC_ENABLE = 7;
  localparam int BIT_TIMER_RUN = 4;
  localparam int BIT_ALARM_ENABLE = 3;
  localparam int BIT_ALARM_FLAG = 2;
  localparam int BIT_LOAD_STROBE = 1;
  localparam int BIT_SNAP_STROBE = 0;

  // alarm routing register field positions
  localparam int BIT_ROUTE_IRQ = 0;
  localparam int BIT_ROUTE_WAKE = 1;
  localparam int BIT_ROUTE_RESET = 2;

  // widths and reset values
  localparam int COUNT_W = 32;
  localparam int ROUTE_W = 3;
  localparam logic [COUNT_W-1:0] COUNT_RST = 32'h0000_0000;
  localparam logic [COUNT_W-1:0] COUNT_ONE = 32'h0000_0001;
  localparam logic [COUNT_W-1:0] CAPTURE_RST = 32'h0000_0000;
  localparam logic [COUNT_W-1:0] MATCH_RST = 32'h0000_0000;
  localparam logic [ROUTE_W-1:0] ROUTE_RST = 3'h0;
  localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;

endpackage : rtc_pkg

/* hw/rtc_osc_tick.sv */
// oscillator pin synchroniser and rising-edge tick generator
`timescale 1ns/100ps
module rtc_osc_tick (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // oscillator pin, asynchronous to pclk
  input wire logic osc_pin,
  // one-pclk pulse per oscillator cycle
  output logic osc_tick
);

  logic sync_a;
  logic sync_b;
  logic sync_c;

  // two-flop synchroniser; only sync_b reads sync_a
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
    end else begin
      sync_a <= osc_pin;
      sync_b <= sync_a;
    end
  end

  // edge detect on the settled copy, tick comes from a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_c <= 1'b0;
      osc_tick <= 1'b0;
    end else begin
      sync_c <= sync_b;
      osc_tick <= sync_b & ~sync_c;
    end
  end

endmodule : rtc_osc_tick

/* hw/rtc_timer_alarm.sv */
// 32-bit oscillator-cycle timer with match alarm and capture path
//
// Summary of operation
// RQ1: counter advances once per oscillator cycle while run bit is set.
// RQ2: alarm can drive interrupt, wake or reset outputs per routing bits.
// RQ3: with auto-reset, counter clears one oscillator cycle after alarm.
// RQ4: writing 1 to the alarm flag position enables auto-reset.
// RQ5: software programs match one below the interval when auto-reset.
// RQ6: load and snapshot work while the counter keeps running.
// RQ7: count is exchanged with software only through capture registers.
// RQ8: load: fill capture, write load strobe, counter takes capture.
// RQ9: hardware clears load strobe once the counter is loaded.
// RQ10: writing snap strobe copies the counter into capture.
// RQ11: snap strobe clears when done; software polls before reading.
// RQ12: alarm only on exact 32-bit equality of counter and match.
// RQ13: software disables alarm, sets match, then re-enables alarm.
// RQ14: clearing alarm enable also clears the alarm flag.
// RQ15: re-enable without new match gives next alarm after full wrap.
// RQ16: alarm flag lasts at most one oscillator cycle.
// RQ17: without auto-reset counter wraps to zero and keeps counting.
// RQ18: run bit 0 holds the counter, 1 resumes counting.
// RQ19: oscillator domain events are synchronised before strobes clear.
// RQ20: without auto-reset counter runs past match, one alarm per wrap.
//
// Chosen here: the APB interface to the registers.
`timescale 1ns/100ps
module rtc_timer_alarm
  import rtc_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // oscillator pin
  input wire logic osc_pin,
  // oscillator analog enable and alarm routing outputs
  output logic osc_enable,
  output logic alarm_irq,
  output logic alarm_wake,
  output logic alarm_reset
);

  // control fields
  logic timer_run;
  logic alarm_enable;
  logic autoreset;
  logic load_strobe;
  logic snap_strobe;
  logic alarm_flag;
  logic [ROUTE_W-1:0] alarm_route;

  // data path
  logic [COUNT_W-1:0] count;
  logic [COUNT_W-1:0] capture;
  logic [COUNT_W-1:0] match_value;
  logic [COUNT_W-1:0] next_count;
  logic count_moves;
  logic autoreset_due;

  // bus decode
  logic osc_tick;
  logic bus_access;
  logic bus_write;
  logic wr_control;
  logic wr_capture;
  logic wr_match;
  logic wr_route;

  // true for offsets that hold a register
  function automatic logic addr_mapped(input logic [7:0] addr);
    addr_mapped = (addr == OFF_CONTROL) || (addr == OFF_CAPTURE) ||
                  (addr == OFF_MATCH) || (addr == OFF_ALARM_CFG);
  endfunction : addr_mapped

  // read multiplexer; unmapped offsets read zero
  function automatic logic [31:0] read_mux(input logic [7:0] addr);
    logic [31:0] value;
    value = RDATA_ZERO;
    case (addr)
      OFF_CONTROL: begin
        value[BIT_OSC_ENABLE] = osc_enable;
        value[BIT_TIMER_RUN] = timer_run;
        value[BIT_ALARM_ENABLE] = alarm_enable;
        value[BIT_ALARM_FLAG] = alarm_flag;
        value[BIT_LOAD_STROBE] = load_strobe;
        value[BIT_SNAP_STROBE] = snap_strobe;
      end
      OFF_CAPTURE: value = capture; // count only seen here [RQ7]
      OFF_MATCH: value = match_value;
      OFF_ALARM_CFG: value[ROUTE_W-1:0] = alarm_route;
      default: value = RDATA_ZERO;
    endcase
    read_mux = value;
  endfunction : read_mux

  // oscillator edges reach pclk only through the synchroniser [RQ19]
  rtc_osc_tick u_osc_tick (
    .pclk(pclk),
    .presetn(presetn),
    .osc_pin(osc_pin),
    .osc_tick(osc_tick)
  );

  // a transfer completes at the edge where pready is sampled high
  assign bus_access = psel & penable & pready;
  assign bus_write = bus_access & pwrite;
  assign wr_control = bus_write & (paddr == OFF_CONTROL);
  assign wr_capture = bus_write & (paddr == OFF_CAPTURE);
  assign wr_match = bus_write & (paddr == OFF_MATCH);
  assign wr_route = bus_write & (paddr == OFF_ALARM_CFG);

  // apb answer: one wait state, data and error registered with pready
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= RDATA_ZERO;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & penable & ~pready;
      if (psel && penable && !pready) begin
        prdata <= pwrite ? RDATA_ZERO : read_mux(paddr);
        pslverr <= ~addr_mapped(paddr);
      end
    end
  end

  // plain control bits owned by software
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_enable <= 1'b0;
      timer_run <= 1'b0;
      alarm_enable <= 1'b0;
      autoreset <= 1'b0;
    end else if (wr_control) begin
      osc_enable <= pwdata[BIT_OSC_ENABLE];
      timer_run <= pwdata[BIT_TIMER_RUN]; // [RQ18]
      alarm_enable <= pwdata[BIT_ALARM_ENABLE];
      // the flag position doubles as the auto-reset enable on writes
      autoreset <= pwdata[BIT_ALARM_FLAG]; // [RQ4]
    end
  end

  // match and routing registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      match_value <= MATCH_RST;
      alarm_route <= ROUTE_RST;
    end else begin
      if (wr_match) begin
        match_value <= pwdata;
      end
      if (wr_route) begin
        alarm_route <= pwdata[ROUTE_W-1:0];
      end
    end
  end

  // next counter value for this oscillator cycle
  assign autoreset_due = alarm_flag & autoreset;
  always_comb begin
    next_count = count;
    count_moves = 1'b0;
    if (load_strobe) begin
      next_count = capture; // [RQ8]
      count_moves = 1'b1;
    end else if (autoreset_due) begin
      next_count = COUNT_RST; // [RQ3]
      count_moves = 1'b1;
    end else if (timer_run) begin
      // plain add wraps from all ones to zero [RQ17]
      next_count = count + COUNT_ONE; // [RQ1]
      count_moves = 1'b1;
    end
  end

  // counter only moves on oscillator ticks, never stopped for access [RQ6]
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= COUNT_RST;
    end else if (osc_tick) begin
      count <= next_count; // [RQ18]
    end
  end

  // capture: a snapshot on the tick beats a bus write in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      capture <= CAPTURE_RST;
    end else if (osc_tick && snap_strobe) begin
      capture <= count; // [RQ10]
    end else if (wr_capture) begin
      capture <= pwdata; // [RQ7]
    end
  end

  // strobes: set by software, cleared on the tick that did the work;
  // a new write in that same cycle wins so no request is lost
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      load_strobe <= 1'b0;
      snap_strobe <= 1'b0;
    end else begin
      if (wr_control && pwdata[BIT_LOAD_STROBE]) begin
        load_strobe <= 1'b1;
      end else if (osc_tick) begin
        load_strobe <= 1'b0; // [RQ9] [RQ19]
      end
      if (wr_control && pwdata[BIT_SNAP_STROBE]) begin
        snap_strobe <= 1'b1;
      end else if (osc_tick) begin
        snap_strobe <= 1'b0; // [RQ11] [RQ19]
      end
    end
  end

  // alarm flag: raised when the counter steps onto the match value, and
  // dropped on the next tick; a stopped counter cannot re-raise it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      alarm_flag <= 1'b0;
    end else if (osc_tick) begin
      // exact compare; counter runs past match, next hit after wrap
      alarm_flag <= alarm_enable & count_moves &
                    (next_count == match_value); // [RQ12] [RQ15] [RQ20]
    end else if (wr_control && !pwdata[BIT_ALARM_ENABLE]) begin
      alarm_flag <= 1'b0; // [RQ14]
    end
  end

  // alarm routing to the system, registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      alarm_irq <= 1'b0;
      alarm_wake <= 1'b0;
      alarm_reset <= 1'b0;
    end else begin
      alarm_irq <= alarm_flag & alarm_route[BIT_ROUTE_IRQ]; // [RQ2]
      alarm_wake <= alarm_flag & alarm_route[BIT_ROUTE_WAKE]; // [RQ2]
      alarm_reset <= alarm_flag & alarm_route[BIT_ROUTE_RESET]; // [RQ2]
    end
  end

  // checks

  property p_count_step;
    @(posedge pclk) disable iff (!presetn)
    (osc_tick && timer_run && !load_strobe && !autoreset_due)
      |=> (count == $past(count) + COUNT_ONE);
  endproperty
  a_count_step: assert property (p_count_step) // [RQ1]
    else $error("counter did not advance by one on tick");

  property p_count_hold;
    @(posedge pclk) disable iff (!presetn)
    (!timer_run && !load_strobe && !autoreset_due) |=> $stable(count);
  endproperty
  a_count_hold: assert property (p_count_hold) // [RQ18]
    else $error("stopped counter changed");

  property p_autoreset_clear;
    @(posedge pclk) disable iff (!presetn)
    (osc_tick && autoreset_due && !load_strobe) |=> (count == COUNT_RST);
  endproperty
  a_autoreset_clear: assert property (p_autoreset_clear) // [RQ3]
    else $error("auto-reset did not clear counter");

  property p_load_done;
    @(posedge pclk) disable iff (!presetn)
    (osc_tick && load_strobe && !(wr_control && pwdata[BIT_LOAD_STROBE]))
      |=> (!load_strobe && count == $past(capture));
  endproperty
  a_load_done: assert property (p_load_done) // [RQ9]
    else $error("load did not complete on tick");

  property p_snap_done;
    @(posedge pclk) disable iff (!presetn)
    (osc_tick && snap_strobe && !(wr_control && pwdata[BIT_SNAP_STROBE]))
      |=> (!snap_strobe && capture == $past(count));
  endproperty
  a_snap_done: assert property (p_snap_done) // [RQ11]
    else $error("snapshot did not complete on tick");

  property p_flag_short;
    @(posedge pclk) disable iff (!presetn)
    (alarm_flag && osc_tick) |=> (!alarm_flag || count == match_value);
  endproperty
  a_flag_short: assert property (p_flag_short) // [RQ16]
    else $error("alarm flag held past one oscillator cycle");

  // match and enable as they stood at the tick that raised the flag; a
  // disable or match write on that same edge must not trip this check
  property p_flag_equal;
    @(posedge pclk) disable iff (!presetn)
    $rose(alarm_flag) |->
      (count == $past(match_value) && $past(alarm_enable));
  endproperty
  a_flag_equal: assert property (p_flag_equal) // [RQ12]
    else $error("alarm raised without exact match");

  property p_disable_clears;
    @(posedge pclk) disable iff (!presetn)
    (wr_control && !pwdata[BIT_ALARM_ENABLE] && !osc_tick)
      |=> (!alarm_flag && !alarm_enable);
  endproperty
  a_disable_clears: assert property (p_disable_clears) // [RQ14]
    else $error("alarm disable left flag set");

  property p_route_irq;
    @(posedge pclk) disable iff (!presetn)
    (alarm_flag && alarm_route[BIT_ROUTE_IRQ]) |=> alarm_irq;
  endproperty
  a_route_irq: assert property (p_route_irq) // [RQ2]
    else $error("alarm not routed to interrupt");

  property p_route_wake;
    @(posedge pclk) disable iff (!presetn)
    (alarm_flag && alarm_route[BIT_ROUTE_WAKE]) |=> alarm_wake;
  endproperty
  a_route_wake: assert property (p_route_wake) // [RQ2]
    else $error("alarm not routed to wake");

  property p_route_reset;
    @(posedge pclk) disable iff (!presetn)
    (alarm_flag && alarm_route[BIT_ROUTE_RESET]) |=> alarm_reset;
  endproperty
  a_route_reset: assert property (p_route_reset) // [RQ2]
    else $error("alarm not routed to reset");

  property p_route_quiet;
    @(posedge pclk) disable iff (!presetn)
    !alarm_flag |=> (!alarm_irq && !alarm_wake && !alarm_reset);
  endproperty
  a_route_quiet: assert property (p_route_quiet) // [RQ2]
    else $error("alarm output raised without alarm flag");

  property p_wrap;
    @(posedge pclk) disable iff (!presetn)
    (osc_tick && timer_run && !load_strobe && !autoreset_due &&
     count == ~COUNT_RST) |=> (count == COUNT_RST);
  endproperty
  a_wrap: assert property (p_wrap) // [RQ17]
    else $error("counter did not wrap to zero");

endmodule : rtc_timer_alarm

/* tb/rtc_timer_alarm_tb.sv */
// self-checking bench for the timer/alarm block, apb master and osc stimulus
`timescale 1ns/100ps
module rtc_timer_alarm_tb;
  import rtc_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, osc_pin, e;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd, v, m;
  logic osc_enable, alarm_irq, alarm_wake, alarm_reset;
  logic [2:0] rt;
  int err_total, cmp_count, seed, n;

  rtc_timer_alarm i_rtc_timer_alarm (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .osc_pin(osc_pin), .osc_enable(osc_enable), .alarm_irq(alarm_irq),
    .alarm_wake(alarm_wake), .alarm_reset(alarm_reset));

  // 125 MHz system clock
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  task automatic results;
    if (err_total == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : results

  task automatic check(input logic [31:0] got, exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask : check

  // one apb transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    rd = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 50) check(1'b0, 1'b1, "pready never came");
  endtask : apb

  // whole oscillator cycles, slow against pclk so the synchroniser sees each
  task automatic osc(input int c);
    repeat (c) begin
      @(posedge pclk);
      osc_pin <= 1'b1;
      repeat (4) @(posedge pclk);
      osc_pin <= 1'b0;
      repeat (4) @(posedge pclk);
    end
    repeat (4) @(posedge pclk);
  endtask : osc

  // stop the counter and read it back through a snapshot
  task automatic snap(input logic [31:0] exp);
    apb(1'b1, OFF_CONTROL, 32'h0000_0080);
    osc(2);
    apb(1'b1, OFF_CONTROL, 32'h0000_0081);
    apb(1'b0, OFF_CONTROL, 32'h0000_0000);
    check(rd[BIT_SNAP_STROBE], 1'b1, "snap pending");
    osc(1);
    apb(1'b0, OFF_CONTROL, 32'h0000_0000);
    check(rd[BIT_SNAP_STROBE], 1'b0, "snap done");
    apb(1'b0, OFF_CAPTURE, 32'h0000_0000);
    check(rd, exp, "snapshot count");
  endtask : snap

  function automatic logic [31:0] alarm_out(input logic on);
    return on ? {29'h0, rt} : 32'h0000_0000;
  endfunction : alarm_out

  task automatic outs(input logic on, input string what);
    check({29'h0, alarm_reset, alarm_wake, alarm_irq}, alarm_out(on), what);
  endtask : outs

  // watchdog: fires after 25k pclk cycles; the whole run needs well under that
  initial begin
    #200_000;
    check(1'b0, 1'b1, "watchdog expired");
    results();
  end

  initial begin
    seed = 47357;
    err_total = 0;
    cmp_count = 0;
    {psel, penable, pwrite, paddr, pwdata, osc_pin, presetn} = '0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    // reset values and an unmapped place, which must ignore writes
    apb(1'b0, OFF_CONTROL, 32'h0000_0000);
    check(rd, RDATA_ZERO, "control reset");
    apb(1'b0, OFF_MATCH, 32'h0000_0000);
    check(rd, MATCH_RST, "match reset");
    apb(1'b1, 8'h40, 32'hffff_ffff);
    check(e, 1'b1, "unmapped write err");
    apb(1'b0, 8'h40, 32'h0000_0000);
    check(e, 1'b1, "unmapped read err");
    check(rd, RDATA_ZERO, "unmapped read data");
    // load while running, count n cycles, wrap at the top corner
    for (int i = 0; i < 4; i++) begin
      v = (i == 0) ? 32'hffff_fffe : $random(seed);
      n = (i == 0) ? 3 : ($unsigned($random(seed)) % 5) + 1;
      apb(1'b1, OFF_CAPTURE, v);
      apb(1'b1, OFF_CONTROL, 32'h0000_0092);
      apb(1'b0, OFF_CONTROL, 32'h0000_0000);
      check(rd[BIT_LOAD_STROBE], 1'b1, "load pending");
      check(osc_enable, 1'b1, "osc enable");
      osc(1);
      apb(1'b0, OFF_CONTROL, 32'h0000_0000);
      check(rd[BIT_LOAD_STROBE], 1'b0, "load done");
      osc(n);
      snap(v + n);
    end
    // alarm without auto-reset: exact match only, one cycle wide
    rt = 3'($unsigned($random(seed)) % 7 + 1);
    m = $random(seed);
    apb(1'b1, OFF_ALARM_CFG, {29'h0, rt});
    apb(1'b1, OFF_CONTROL, 32'h0000_0080);
    apb(1'b1, OFF_MATCH, m);
    apb(1'b1, OFF_CAPTURE, m - 32'h0000_0002);
    apb(1'b1, OFF_CONTROL, 32'h0000_009a);
    osc(2);
    outs(1'b0, "early alarm");
    osc(1);
    outs(1'b1, "alarm routing");
    apb(1'b0, OFF_CONTROL, 32'h0000_0000);
    check(rd[BIT_ALARM_FLAG], 1'b1, "alarm flag");
    osc(1);
    outs(1'b0, "flag width");
    // re-enable with the same match: no alarm until the counter wraps
    apb(1'b1, OFF_CONTROL, 32'h0000_0090);
    apb(1'b1, OFF_CONTROL, 32'h0000_0098);
    osc(2);
    outs(1'b0, "no alarm before wrap");
    // auto-reset: counter clears one cycle after the alarm
    apb(1'b1, OFF_CAPTURE, m - 32'h0000_0001);
    apb(1'b1, OFF_CONTROL, 32'h0000_009e);
    osc(2);
    outs(1'b1, "autoreset alarm");
    osc(1);
    snap(32'h0000_0000);
    // disabling alarms drops a raised flag at once; all routes on here
    rt = 3'h7;
    apb(1'b1, OFF_ALARM_CFG, {29'h0, rt});
    apb(1'b1, OFF_CAPTURE, m - 32'h0000_0001);
    apb(1'b1, OFF_CONTROL, 32'h0000_009a);
    osc(2);
    outs(1'b1, "alarm again");
    apb(1'b1, OFF_CONTROL, 32'h0000_0090);
    apb(1'b0, OFF_CONTROL, 32'h0000_0000);
    check(rd[BIT_ALARM_FLAG], 1'b0, "flag cleared");
    outs(1'b0, "outputs cleared");
    results();
  end
endmodule : rtc_timer_alarm_tb
